// ---- rtl/pmc_ctrl.sv ----
// power mode controller: active mode and four power modes, wishbone slave
// assumes classic wishbone master, synchronous inputs on clk_i
// Summary of operation
// R1: active plus four progressively deeper power modes
// R2: idle trigger gates cpu clock until interrupt
// R3: clock stop: fast oscillators off, slow kept
// R4: clock stop/regulator off wake on reset/ext/timer
// R5: regulator off: regulator, fast oscillators off
// R6: deep off: all off, only ports wake
// R7: pins hold direction and level while sleeping
// R8: regulator off and deep off reset usb
// R9: interrupt wake resumes, reset restarts program
// R10: any enabled interrupt ends cpu idle
// R11: wake restarts oscillators; rc until crystal stable
// R12: mode field first, then idle trigger
// R13: wake clears mode field and idle trigger
// R14: nonzero mode field blocks port/timer interrupts
// R15: entering power mode clears mode field
// R16: firmware clears mode in wake handlers
// R17: firmware disables non-wake interrupts first
// R18: firmware waits crystal stable before sleeping
// R19: firmware keeps active interval long enough
// R20: deeper modes run short or long sequences
// R21: idle trigger reads zero, writing one enters
// R22: mode field two bits, idle..deep off
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`include "pmc_defs.svh"

module pmc_ctrl
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// wishbone
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [`PMC_ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	// wake and interrupt sources, oscillator stable flags
	input  wire logic                   irq_any_i,
	input  wire logic                   port_irq_i,
	input  wire logic                   timer_irq_i,
	input  wire logic                   crystal_oscillator_ready_i,
	input  wire logic                   hfrc_ready_i,
	// pins to retain
	input  wire logic [7:0]             pin_out_i,
	input  wire logic [7:0]             pin_oe_n_i,
	output logic      [7:0]             pin_out_o,
	output logic      [7:0]             pin_oe_n_o,
	// power and clock controls
	output logic                        cpu_clk_en_o,
	output logic                        periph_clk_en_o,
	output logic                        crystal_oscillator_en_o,
	output logic                        hfrc_en_o,
	output logic                        lsosc_en_o,
	output logic                        sleep_timer_en_o,
	output logic                        regulator_en_o,
	output logic                        sysclk_is_crystal_oscillator_o,
	output logic                        usb_rst_o,
	output logic                        wake_irq_en_o,
	output logic                        cpu_restart_o,
	output logic                        asleep_o
);

	typedef struct packed
	{
		pmc_pkg::pmc_state_e st;
		logic [1:0]          mode;
		logic [1:0]          target;
		logic                sysclk_sel;
		logic                lsclk_sel;
		logic                usb_en;
		logic                crystal_oscillator_was;
		logic                hfrc_was;
		logic [7:0]          pin_out;
		logic [7:0]          pin_oe_n;
		logic                ack;
		logic [31:0]         rdata;
		logic                restart;
	} pmc_ctrl_s;

	pmc_ctrl_s r;
	pmc_ctrl_s next_r;
	logic      tmr_load;
	logic [`PMC_CNT_W-1:0] tmr_count;
	logic      tmr_done;
	logic      wb_req;
	logic      wb_wr;
	logic      deep;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic wakes(input logic [1:0] sel, input logic port_irq,
		input logic timer_irq);
		wakes = port_irq || (timer_irq && sel != 2'(pmc_pkg::PMC_SEL_DEEPOFF)); // R4 R6
	endfunction : wakes

	function automatic logic [`PMC_CNT_W-1:0] seq_len(input logic [1:0] sel);
		if (sel == 2'(pmc_pkg::PMC_SEL_CLKSTOP))
			seq_len = `PMC_CNT_W'(`PMC_SHORT_CYC); // R20
		else
			seq_len = `PMC_CNT_W'(`PMC_LONG_CYC); // R20
	endfunction : seq_len

	assign wb_req = wb_cyc_i && wb_stb_i && !r.ack;
	assign wb_wr  = wb_req && wb_we_i && wb_sel_i[0];
	assign deep   = r.target != 2'(pmc_pkg::PMC_SEL_IDLE);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_r    = r;
		tmr_load  = 1'b0;
		tmr_count = seq_len(r.target);
		next_r.ack     = wb_req;
		next_r.restart = 1'b0;

		// register writes
		if (wb_wr && wb_adr_i == `PMC_OFF_SLEEP)
			next_r.mode = wb_dat_i[`PMC_MODE_LSB+:2]; // R12 R22
		if (wb_wr && wb_adr_i == `PMC_OFF_SLEEP)
			next_r.usb_en = wb_dat_i[`PMC_USB_EN_BIT];
		if (wb_wr && wb_adr_i == `PMC_OFF_CLKCTL)
		begin
			next_r.sysclk_sel = wb_dat_i[`PMC_SYSCLK_BIT];
			next_r.lsclk_sel  = wb_dat_i[`PMC_LSCLK_BIT];
		end

		case (r.st)
			pmc_pkg::PMC_ST_ACTIVE:
			begin
				if (wb_wr && wb_adr_i == `PMC_OFF_PWRCTL && wb_dat_i[`PMC_IDLE_BIT]) // R21
				begin
					next_r.target = r.mode; // R12
					next_r.pin_out  = pin_out_i;  // R7
					next_r.pin_oe_n = pin_oe_n_i; // R7
					next_r.crystal_oscillator_was = r.sysclk_sel == 1'b0 || crystal_oscillator_ready_i; // R11
					next_r.hfrc_was = 1'b1;
					if (r.mode == 2'(pmc_pkg::PMC_SEL_IDLE))
						next_r.st = pmc_pkg::PMC_ST_IDLE; // R2
					else
					begin
						next_r.st = pmc_pkg::PMC_ST_DOWN; // R20
						tmr_load  = 1'b1;
						tmr_count = seq_len(r.mode);
					end
				end
			end
			pmc_pkg::PMC_ST_IDLE:
			begin
				if (irq_any_i)
					next_r.st = pmc_pkg::PMC_ST_ACTIVE; // R10
			end
			pmc_pkg::PMC_ST_DOWN:
			begin
				if (wakes(r.target, port_irq_i, timer_irq_i) && r.mode == 2'h0)
				begin
					next_r.st = pmc_pkg::PMC_ST_ACTIVE; // R16
				end
				else if (tmr_done)
				begin
					next_r.st   = pmc_pkg::PMC_ST_SLEEP;
					next_r.mode = `PMC_MODE_RST; // R15
					if (r.target[1])
						next_r.usb_en = 1'b0; // R8
				end
			end
			pmc_pkg::PMC_ST_SLEEP:
			begin
				if (wakes(r.target, port_irq_i, timer_irq_i))
				begin
					next_r.st   = pmc_pkg::PMC_ST_UP; // R4 R6
					next_r.mode = `PMC_MODE_RST; // R13
					tmr_load    = 1'b1;
				end
			end
			pmc_pkg::PMC_ST_UP:
			begin
				if (tmr_done)
					next_r.st = (r.sysclk_sel == 1'b0) ? pmc_pkg::PMC_ST_XWAIT
						: pmc_pkg::PMC_ST_ACTIVE; // R11
			end
			pmc_pkg::PMC_ST_XWAIT:
			begin
				if (crystal_oscillator_ready_i)
					next_r.st = pmc_pkg::PMC_ST_ACTIVE; // R11
			end
			default:
				next_r.st = pmc_pkg::PMC_ST_ACTIVE;
		endcase

		// read data
		next_r.rdata = 32'h0;
		if (wb_req)
		begin
			case (wb_adr_i)
				`PMC_OFF_PWRCTL: next_r.rdata = 32'h0; // R21
				`PMC_OFF_SLEEP:
				begin
					next_r.rdata[`PMC_MODE_LSB+:2]   = r.mode;
					next_r.rdata[`PMC_USB_EN_BIT]   = r.usb_en;
					next_r.rdata[`PMC_CRYSTAL_OSCILLATOR_STB_BIT] = crystal_oscillator_ready_i;
					next_r.rdata[`PMC_HFRC_STB_BIT] = hfrc_ready_i;
				end
				`PMC_OFF_CLKCTL:
				begin
					next_r.rdata[`PMC_SYSCLK_BIT] = r.sysclk_sel;
					next_r.rdata[`PMC_LSCLK_BIT]  = r.lsclk_sel;
				end
				`PMC_OFF_STATUS: next_r.rdata[2:0] = r.st;
				default:         next_r.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			r            <= '0;
			r.st         <= pmc_pkg::PMC_ST_ACTIVE;
			r.sysclk_sel <= `PMC_SYSCLK_RST;
			r.lsclk_sel  <= `PMC_LSCLK_RST;
			r.restart    <= 1'b1; // R9
		end
		else
			r <= next_r;
	end

	pmc_seq_timer u_tmr
	(
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.load_i  (tmr_load),
		.count_i (tmr_count),
		.done_o  (tmr_done)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	logic active;
	logic sleeping;
	assign active   = r.st == pmc_pkg::PMC_ST_ACTIVE;
	assign sleeping = r.st == pmc_pkg::PMC_ST_SLEEP || r.st == pmc_pkg::PMC_ST_DOWN;

	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.rdata;
	assign asleep_o = sleeping;
	assign cpu_restart_o  = r.restart; // R9
	assign cpu_clk_en_o   = active || r.st == pmc_pkg::PMC_ST_XWAIT; // R2
	assign periph_clk_en_o = !(r.st == pmc_pkg::PMC_ST_SLEEP); // R3
	assign crystal_oscillator_en_o  = r.st == pmc_pkg::PMC_ST_SLEEP ? 1'b0
		: (r.st == pmc_pkg::PMC_ST_ACTIVE || r.st == pmc_pkg::PMC_ST_IDLE)
		? (r.sysclk_sel == 1'b0) : r.crystal_oscillator_was; // R3 R11
	assign hfrc_en_o  = r.st == pmc_pkg::PMC_ST_SLEEP ? 1'b0
		: (r.st == pmc_pkg::PMC_ST_UP) ? r.hfrc_was : 1'b1; // R3 R11
	assign lsosc_en_o = !(r.st == pmc_pkg::PMC_ST_SLEEP
		&& r.target == 2'(pmc_pkg::PMC_SEL_DEEPOFF)); // R6
	assign sleep_timer_en_o = lsosc_en_o; // R3 R5
	assign regulator_en_o   = !(r.st == pmc_pkg::PMC_ST_SLEEP && r.target[1]); // R1 R5 R6
	assign sysclk_is_crystal_oscillator_o = r.sysclk_sel == 1'b0 && crystal_oscillator_ready_i
		&& r.st != pmc_pkg::PMC_ST_XWAIT; // R11
	assign usb_rst_o      = !r.usb_en; // R8
	assign wake_irq_en_o  = r.mode == 2'h0; // R14
	assign pin_out_o  = (sleeping && deep) ? r.pin_out  : pin_out_i;  // R7
	assign pin_oe_n_o = (sleeping && deep) ? r.pin_oe_n : pin_oe_n_i; // R7

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_idle_gates_cpu: assert property (@(posedge clk_i) disable iff (rst_i) // R2
		r.st == pmc_pkg::PMC_ST_IDLE |-> !cpu_clk_en_o)
		else $error("cpu clock running in idle");
	a_idle_irq_wake: assert property (@(posedge clk_i) disable iff (rst_i) // R10
		r.st == pmc_pkg::PMC_ST_IDLE && irq_any_i |=> active)
		else $error("idle not left on interrupt");
	a_clkstop_fast_off: assert property (@(posedge clk_i) disable iff (rst_i) // R3
		r.st == pmc_pkg::PMC_ST_SLEEP |-> !crystal_oscillator_en_o && !hfrc_en_o)
		else $error("fast oscillator on while asleep");
	a_regoff_reg: assert property (@(posedge clk_i) disable iff (rst_i) // R5
		r.st == pmc_pkg::PMC_ST_SLEEP && r.target == 2'h2 |-> !regulator_en_o
		&& sleep_timer_en_o)
		else $error("regulator off mode wrong");
	a_deep_all_off: assert property (@(posedge clk_i) disable iff (rst_i) // R6
		r.st == pmc_pkg::PMC_ST_SLEEP && r.target == 2'h3 |-> !lsosc_en_o && !regulator_en_o)
		else $error("deep off mode wrong");
	a_deep_no_timer: assert property (@(posedge clk_i) disable iff (rst_i) // R6
		!rst_i && r.st == pmc_pkg::PMC_ST_SLEEP && r.target == 2'h3 && !port_irq_i
		|=> r.st == pmc_pkg::PMC_ST_SLEEP)
		else $error("deep off woke without port");
	a_enter_clears: assert property (@(posedge clk_i) disable iff (rst_i) // R15
		r.st == pmc_pkg::PMC_ST_DOWN ##1 r.st == pmc_pkg::PMC_ST_SLEEP |-> r.mode == 2'h0)
		else $error("mode not cleared on entry");
	a_block_irq: assert property (@(posedge clk_i) disable iff (rst_i) // R14
		r.mode != 2'h0 |-> !wake_irq_en_o)
		else $error("wake interrupts open with mode set");
	a_usb_lost: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		r.st == pmc_pkg::PMC_ST_SLEEP && r.target[1] |-> usb_rst_o)
		else $error("usb kept in deep mode");
	a_idle_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R21
		wb_req && !wb_we_i && wb_adr_i == `PMC_OFF_PWRCTL |=> wb_ack_o && wb_dat_o == 32'h0)
		else $error("idle trigger read nonzero");
	a_pins_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R7
		r.st == pmc_pkg::PMC_ST_SLEEP && deep && $stable(r.st) |-> $stable(pin_out_o))
		else $error("pins moved while asleep");
	a_active_all_on: assert property (@(posedge clk_i) disable iff (rst_i) // R1
		active |-> cpu_clk_en_o && periph_clk_en_o && regulator_en_o && lsosc_en_o)
		else $error("supply or clock off in active mode");
	a_idle_periph_on: assert property (@(posedge clk_i) disable iff (rst_i) // R2
		r.st == pmc_pkg::PMC_ST_IDLE |-> periph_clk_en_o && regulator_en_o && !asleep_o)
		else $error("peripherals stopped in cpu idle");
	a_clkstop_kept: assert property (@(posedge clk_i) disable iff (rst_i) // R3
		r.st == pmc_pkg::PMC_ST_SLEEP && r.target == 2'h1
		|-> regulator_en_o && sleep_timer_en_o && lsosc_en_o)
		else $error("clock stop mode lost regulator or timer");
	a_sleep_wakes_up: assert property (@(posedge clk_i) disable iff (rst_i) // R4 R13
		r.st == pmc_pkg::PMC_ST_SLEEP && (port_irq_i || (timer_irq_i && r.target != 2'h3))
		|=> r.st == pmc_pkg::PMC_ST_UP && wake_irq_en_o)
		else $error("wake event not taken");
	a_down_blocks_irq: assert property (@(posedge clk_i) disable iff (rst_i) // R14
		r.st == pmc_pkg::PMC_ST_DOWN && r.mode != 2'h0 |=> !active)
		else $error("power-down left while mode field set");
	a_usb_cleared: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		r.st == pmc_pkg::PMC_ST_DOWN && r.target[1] && r.mode != 2'h0 && tmr_done
		|=> usb_rst_o)
		else $error("usb kept on deep entry");
	a_up_fast_on: assert property (@(posedge clk_i) disable iff (rst_i) // R11
		r.st == pmc_pkg::PMC_ST_UP |-> hfrc_en_o && regulator_en_o && !cpu_clk_en_o)
		else $error("power-up sequence wrong");
	a_xwait_on_rc: assert property (@(posedge clk_i) disable iff (rst_i) // R11
		r.st == pmc_pkg::PMC_ST_XWAIT |-> hfrc_en_o && crystal_oscillator_en_o && !sysclk_is_crystal_oscillator_o)
		else $error("crystal used before stable");
	a_xwait_leaves: assert property (@(posedge clk_i) disable iff (rst_i) // R11
		r.st == pmc_pkg::PMC_ST_XWAIT && crystal_oscillator_ready_i |=> active)
		else $error("crystal wait not left");
	a_no_restart: assert property (@(posedge clk_i) disable iff (rst_i) // R9
		!$past(rst_i) |-> !cpu_restart_o)
		else $error("program restart without reset");
	a_pins_live: assert property (@(posedge clk_i) disable iff (rst_i) // R7
		active |-> pin_out_o == pin_out_i && pin_oe_n_o == pin_oe_n_i)
		else $error("pins not following core while active");

endmodule : pmc_ctrl

// ---- rtl/pmc_defs.svh ----
// register offsets, field positions, reset values and timing counts of the
// power mode controller; included by the package user files by bare name
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

`define PMC_ADDR_W        4
`define PMC_OFF_PWRCTL    4'h0
`define PMC_OFF_SLEEP     4'h4
`define PMC_OFF_CLKCTL    4'h8
`define PMC_OFF_STATUS    4'hC

`define PMC_IDLE_BIT      0
`define PMC_MODE_LSB      0
`define PMC_USB_EN_BIT    7
`define PMC_CRYSTAL_OSCILLATOR_STB_BIT  6
`define PMC_HFRC_STB_BIT  5
`define PMC_SYSCLK_BIT    0
`define PMC_LSCLK_BIT     1

`define PMC_MODE_RST      2'h0
`define PMC_SYSCLK_RST    1'h1
`define PMC_LSCLK_RST     1'h0

// power-down and power-up sequence lengths, ns
`define PMC_SHORT_SEQ_NS  40
`define PMC_LONG_SEQ_NS   200
`define PMC_CLK_NS        5
`define PMC_SHORT_CYC     ((`PMC_SHORT_SEQ_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_LONG_CYC      ((`PMC_LONG_SEQ_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_CNT_W         8

`endif

// ---- rtl/pmc_pkg.sv ----
// types of the power mode controller
// assumes pmc_defs.svh for the numeric constants
package pmc_pkg;

	typedef enum logic [1:0]
	{
		PMC_SEL_IDLE,
		PMC_SEL_CLKSTOP,
		PMC_SEL_REGOFF,
		PMC_SEL_DEEPOFF
	} pmc_sel_e;

	typedef enum logic [2:0]
	{
		PMC_ST_ACTIVE,
		PMC_ST_IDLE,
		PMC_ST_DOWN,
		PMC_ST_SLEEP,
		PMC_ST_UP,
		PMC_ST_XWAIT
	} pmc_state_e;

endpackage : pmc_pkg

// ---- rtl/pmc_seq_timer.sv ----
// down counter timing the power-down and power-up sequences
// assumes one clock, synchronous active-high reset
`include "pmc_defs.svh"

module pmc_seq_timer
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  load_i,
	input  wire logic [`PMC_CNT_W-1:0] count_i,
	output logic                       done_o
);

	typedef struct packed
	{
		logic [`PMC_CNT_W-1:0] cnt;
	} pmc_tmr_s;

	pmc_tmr_s r;
	pmc_tmr_s next_r;

	always_comb
	begin
		next_r = r;
		if (load_i)
			next_r.cnt = count_i;
		else if (r.cnt != '0)
			next_r.cnt = r.cnt - `PMC_CNT_W'(1);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			r <= '0;
		else
			r <= next_r;
	end

	assign done_o = (r.cnt == '0) && !load_i;

endmodule : pmc_seq_timer

// ---- verif/pmc_osc_model.sv ----
// oscillator model: stable flags rise a startup delay after enable
// assumes enables come from the controller, synchronous to clk_i
module pmc_osc_model
#(
	parameter int CRYSTAL_OSCILLATOR_DLY = 30,
	parameter int HFRC_DLY = 4
)
(
	input  wire logic clk_i,
	input  wire logic crystal_oscillator_en_i,
	input  wire logic hfrc_en_i,
	output logic      crystal_oscillator_ready_o,
	output logic      hfrc_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int xc = 0;
	int hc = 0;

	always @(posedge clk_i)
	begin
		xc <= crystal_oscillator_en_i ? xc + 1 : 0;
		hc <= hfrc_en_i ? hc + 1 : 0;
	end

	// flags drop at once when the oscillator stops
	assign crystal_oscillator_ready_o = crystal_oscillator_en_i && (xc >= CRYSTAL_OSCILLATOR_DLY);
	assign hfrc_ready_o = hfrc_en_i && (hc >= HFRC_DLY);
endmodule : pmc_osc_model

// ---- verif/tb.sv ----
// self-checking bench of the power mode controller
// assumes pmc_ctrl and pmc_osc_model compiled before it
`include "pmc_defs.svh"
`define CHK(a, b) chk((a) === (b))
`define WAITC(c) begin int k; k = 0; while (!(c) && k < 500) begin @(posedge clk_i); k++; end \
	if (!(c)) chk(1'b0); #1; end

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 0, rst_i = 1;
	logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
	logic [3:0]  wb_adr_i = 0, wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 0, wb_dat_o;
	logic        irq_any_i = 0, port_irq_i = 0, timer_irq_i = 0;
	logic        crystal_oscillator_ready_i, hfrc_ready_i;
	logic [7:0]  pin_out_i = 0, pin_oe_n_i = 8'hFF, pin_out_o, pin_oe_n_o;
	logic        cpu_clk_en_o, periph_clk_en_o, crystal_oscillator_en_o, hfrc_en_o, lsosc_en_o;
	logic        sleep_timer_en_o, regulator_en_o, sysclk_is_crystal_oscillator_o, usb_rst_o;
	logic        wake_irq_en_o, cpu_restart_o, asleep_o;
	int          miscompares = 0, n_tests = 0, cyc_cnt = 0, dn = 0;

	always #2.5 clk_i = ~clk_i;

	pmc_ctrl uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_any_i, .port_irq_i, .timer_irq_i,
		.crystal_oscillator_ready_i, .hfrc_ready_i, .pin_out_i, .pin_oe_n_i, .pin_out_o, .pin_oe_n_o,
		.cpu_clk_en_o, .periph_clk_en_o, .crystal_oscillator_en_o, .hfrc_en_o, .lsosc_en_o,
		.sleep_timer_en_o, .regulator_en_o, .sysclk_is_crystal_oscillator_o, .usb_rst_o,
		.wake_irq_en_o, .cpu_restart_o, .asleep_o);

	pmc_osc_model osc (.clk_i(clk_i), .crystal_oscillator_en_i(crystal_oscillator_en_o), .hfrc_en_i(hfrc_en_o),
		.crystal_oscillator_ready_o(crystal_oscillator_ready_i), .hfrc_ready_o(hfrc_ready_i));

	// length of the power-down phase
	always @(posedge clk_i)
		dn <= !asleep_o ? 0 : (periph_clk_en_o ? dn + 1 : dn);

	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt == 20000)
		begin
			miscompares++;
			end_sim();
		end
	end

	task automatic chk(input bit ok);
		n_tests++;
		if (!ok)
		begin
			miscompares++;
			$display("wrong value at %0t ns: output mismatch", $time);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		chk(n < 50);
		q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		#1;
	endtask : wb

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [31:0] q;
		wb(1'b0, a, 8'h0, q);
		`CHK(q & {24'h0, m}, {24'h0, e});
	endtask : rd

	task automatic sl(input logic [1:0] m);
		wr(`PMC_OFF_SLEEP, {6'h20, m});
		`CHK(wake_irq_en_o, m == 0);
		wr(`PMC_OFF_PWRCTL, 8'h01);
		`WAITC(asleep_o && !periph_clk_en_o)
	endtask : sl

	task automatic wake(input logic tmr);
		@(posedge clk_i);
		if (tmr) timer_irq_i <= 1;
		else port_irq_i <= 1;
		`WAITC(!asleep_o)
		@(posedge clk_i);
		timer_irq_i <= 0;
		port_irq_i  <= 0;
		`WAITC(cpu_clk_en_o)
	endtask : wake

	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	initial
	begin
		logic [1:0] m;
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		rd(`PMC_OFF_PWRCTL, 8'hFF, 8'h00);
		rd(`PMC_OFF_CLKCTL, 8'h03, 8'h01);
		rd(`PMC_OFF_SLEEP, 8'h83, 8'h00);
		rd(`PMC_OFF_STATUS, 8'h07, 8'h00);
		rd(4'h2, 8'hFF, 8'h00);
		// cpu idle until any interrupt
		wr(`PMC_OFF_SLEEP, 8'h00);
		wr(`PMC_OFF_PWRCTL, 8'h01);
		`CHK({cpu_clk_en_o, periph_clk_en_o, asleep_o}, 3'b010);
		rd(`PMC_OFF_STATUS, 8'h07, 8'h01);
		rd(`PMC_OFF_PWRCTL, 8'hFF, 8'h00);
		@(posedge clk_i);
		irq_any_i <= 1;
		@(posedge clk_i);
		irq_any_i <= 0;
		#1;
		`CHK(cpu_clk_en_o, 1'b1);
		for (int i = 1; i < 4; i++)
		begin
			m = i[1:0];
			@(posedge clk_i);
			pin_out_i  <= 8'hA5;
			pin_oe_n_i <= 8'h0F;
			sl(m);
			// the cycle at count zero, where done rises, adds one cycle to the timer count
			`CHK(dn, (m == 1 ? `PMC_SHORT_CYC : `PMC_LONG_CYC) + 1);
			`CHK({crystal_oscillator_en_o, hfrc_en_o, cpu_clk_en_o}, 3'b000);
			`CHK(regulator_en_o, m == 1);
			`CHK({lsosc_en_o, sleep_timer_en_o}, {2{m != 3}});
			`CHK(wake_irq_en_o, 1'b1);
			`CHK(usb_rst_o, m != 1);
			@(posedge clk_i);
			pin_out_i  <= 8'h5A;
			pin_oe_n_i <= 8'hF0;
			@(posedge clk_i);
			#1;
			`CHK({pin_out_o, pin_oe_n_o}, 16'hA50F);
			if (m == 3)
			begin
				@(posedge clk_i);
				timer_irq_i <= 1;
				repeat (4) @(posedge clk_i);
				timer_irq_i <= 0;
				#1;
				`CHK(asleep_o, 1'b1);
			end
			wake(m == 2);
			`CHK({cpu_restart_o, pin_out_o}, 9'h05A);
			rd(`PMC_OFF_STATUS, 8'h07, 8'h00);
			rd(`PMC_OFF_SLEEP, 8'h83, m == 1 ? 8'h80 : 8'h00);
		end
		// crystal as system clock, firmware waits for it
		wr(`PMC_OFF_CLKCTL, 8'h00);
		`WAITC(crystal_oscillator_ready_i)
		rd(`PMC_OFF_SLEEP, 8'h40, 8'h40);
		sl(2'h1);
		wake(1'b0);
		`CHK({crystal_oscillator_en_o, sysclk_is_crystal_oscillator_o}, 2'b10);
		rd(`PMC_OFF_STATUS, 8'h07, 8'h05);
		`WAITC(crystal_oscillator_ready_i)
		@(posedge clk_i);
		#1;
		`CHK(sysclk_is_crystal_oscillator_o, 1'b1);
		// reset out of deepest sleep restarts the program
		sl(2'h3);
		@(posedge clk_i);
		rst_i <= 1;
		@(posedge clk_i);
		rst_i <= 0;
		`WAITC(cpu_restart_o)
		rd(`PMC_OFF_STATUS, 8'h07, 8'h00);
		end_sim();
	end
endmodule : tb
